// >>> branch_condition_target_unit.sv
// Branch resolution: taken decision, next address, count and link updates.
// Summary of operation
// - Option bit 0 clear: selected condition bit must equal option bit 1.
// - Option bit 0 set: condition register and index ignored.
// - Count-register form targets count bits 0..29 with two zero bits.
// - Not taken continues at current address plus 4, else target.
// - Link flag set writes current address plus 4 to link register always.
// - Count-register form never decrements count; only link may change.
// - Option bit 4 is only a prediction hint, no architectural effect.
// - Option 16 decrements count, branches if new count nonzero.
// - Option 18 decrements count, branches if new count zero.
// - Option 0 decrements, branches on nonzero count and condition bit 0.
// - Option 8 decrements, branches on nonzero count and condition bit 1.
// - Option 2 decrements, branches on zero count and condition bit 0.
// - Option 10 decrements, branches on zero count and condition bit 1.
// - Option 4 keeps count, branches when condition bit is 0.
// - Option 12 keeps count, branches when condition bit is 1.
// - Option 20 branches unconditionally, to the count-register address in that form, else to the relative target.
// - Condition field n holds lt, gt, eq, so at bits 4n+0..4n+3.
// - Absolute flag set uses base zero, else current address.
// - Relative form with option bit 2 clear decrements and tests count.
// - Displacement gets two zero bits, sign-extended, added to base.
`include "branch_unit_defines.svh"
module branch_condition_target_unit
  import branch_unit_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_issue,
  input wire logic [31:0] i_insn,
  input wire logic [31:0] i_current_insn_address,
  input wire logic [31:0] i_condition_register,
  input wire logic i_count_load,
  input wire logic [31:0] i_count_value,
  input wire logic i_link_load,
  input wire logic [31:0] i_link_value,
  output logic o_resolved,
  output logic o_taken,
  output logic o_predict_hint,
  output logic [31:0] o_next_insn_address,
  output logic [31:0] o_count_register,
  output logic [31:0] o_link_register
);
  branch_decode_if dec_bus();
  branch_state_s state_ff;
  branch_state_s nxt_state;
  logic [31:0] count_dec;
  logic cond_bit;
  logic cond_ok;
  logic count_ok;
  logic go;
  logic [31:0] base;
  logic [31:0] disp;
  logic [31:0] step_addr;

  branch_decoder u_decoder (
    .i_insn(i_insn),
    .dec(dec_bus.decoder)
  );

  always_comb begin
    count_dec = state_ff.count_register - 32'h0000_0001;
    step_addr = i_current_insn_address + `INSN_STEP;
    // condition bit select
    // Field bit 0 is the register's most significant bit, so index k is bit 31-k.
    cond_bit = i_condition_register[5'h1F - dec_bus.condition_index_field];
    cond_ok = dec_bus.branch_options_field[4] | (cond_bit == dec_bus.branch_options_field[3]);
    // option decode
    // Every option value above reduces to these two terms, so no per-value table is kept.
    count_ok = dec_bus.branch_options_field[2] | ((count_dec == 32'h0000_0000) == dec_bus.branch_options_field[1]);
    disp = {{16{dec_bus.displacement_field[13]}}, dec_bus.displacement_field, 2'b00};
    base = dec_bus.absolute_address_flag ? 32'h0000_0000 : i_current_insn_address;
    go = 1'b0;
    nxt_state = state_ff;
    nxt_state.valid = 1'b0;
    if (i_count_load) begin
      nxt_state.count_register = i_count_value;
    end
    if (i_link_load) begin
      nxt_state.link_register = i_link_value;
    end
    if (i_issue && dec_bus.form != FORM_NONE) begin
      nxt_state.valid = 1'b1;
      if (dec_bus.form == FORM_REL) begin
        go = cond_ok & count_ok;
        if (!dec_bus.branch_options_field[2]) begin
          nxt_state.count_register = count_dec;
        end
        nxt_state.next_insn_address = go ? base + disp : step_addr;
      end else begin
        // option bit 2 clear is undefined, so the count test is dropped.
        // unconditional when option bit 0 and bit 2 are set
        go = cond_ok;
        nxt_state.next_insn_address = go ? {state_ff.count_register[31:2], 2'b00} : step_addr;
      end
      nxt_state.taken = go;
      if (dec_bus.link_flag) begin
        nxt_state.link_register = step_addr;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_ff <= '{count_register: `COUNT_RESET, link_register: `LINK_RESET,
                    next_insn_address: 32'h0000_0000, taken: 1'b0, valid: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_resolved = state_ff.valid;
  assign o_taken = state_ff.taken;
  // The hint is passed straight through and never reaches the address path.
  assign o_predict_hint = dec_bus.branch_options_field[0];
  assign o_next_insn_address = state_ff.next_insn_address;
  assign o_count_register = state_ff.count_register;
  assign o_link_register = state_ff.link_register;

  a_fall_through: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form != FORM_NONE) |=> (!o_taken -> o_next_insn_address == $past(step_addr)))
    else $error("Not-taken branch did not go to address plus 4.");
  a_link_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form != FORM_NONE && dec_bus.link_flag) |=> o_link_register == $past(step_addr))
    else $error("Link register not written with address plus 4.");
  a_count_kept: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form == FORM_CTR && !i_count_load) |=> $stable(o_count_register))
    else $error("Count-register form changed the count.");
  a_count_target: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form == FORM_CTR) |=> (o_taken -> o_next_insn_address == {$past(o_count_register[31:2]), 2'b00}))
    else $error("Count target address wrong.");
  a_count_decrement: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form == FORM_REL && !dec_bus.branch_options_field[2] && !i_count_load)
    |=> o_count_register == $past(o_count_register) - 32'h0000_0001)
    else $error("Count not decremented.");
  a_always_taken: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form == FORM_CTR && dec_bus.branch_options_field[4] && dec_bus.branch_options_field[2])
    |=> o_taken)
    else $error("Unconditional branch not taken.");
  a_cond_mismatch: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form != FORM_NONE && !dec_bus.branch_options_field[4]
     && cond_bit != dec_bus.branch_options_field[3]) |=> !o_taken)
    else $error("Condition mismatch still taken.");
  a_abs_target: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_issue && dec_bus.form == FORM_REL && dec_bus.absolute_address_flag)
    |=> (o_taken -> o_next_insn_address == $past(disp)))
    else $error("Absolute target not based at zero.");

  // A relative branch issued without a count load in the same cycle.
  sequence s_rel_issue;
    i_issue && dec_bus.form == FORM_REL && !i_count_load;
  endsequence

  a_count_hold_rel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_rel_issue ##0 dec_bus.branch_options_field[2] |=> $stable(o_count_register))
    else $error("Condition-only branch changed the count.");
  a_zero_test: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_rel_issue ##0 (dec_bus.branch_options_field[4] && !dec_bus.branch_options_field[2])
    |=> o_taken == ((o_count_register == 32'h0000_0000) == $past(dec_bus.branch_options_field[1])))
    else $error("Count-only branch decision wrong.");
  a_both_terms: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_rel_issue ##0 (!dec_bus.branch_options_field[4] && !dec_bus.branch_options_field[2])
    |=> o_taken == (((o_count_register == 32'h0000_0000) == $past(dec_bus.branch_options_field[1]))
                    && ($past(cond_bit) == $past(dec_bus.branch_options_field[3]))))
    else $error("Count and condition branch decision wrong.");
  a_hint_pass: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_predict_hint == i_insn[21])
    else $error("Prediction hint does not follow option bit 4.");
endmodule

// >>> branch_unit_defines.svh
// Constants for the branch condition and target unit.
`ifndef BRANCH_UNIT_DEFINES_SVH
`define BRANCH_UNIT_DEFINES_SVH
`define OPC_COND_REL 6'h10
`define OPC_COND_REG 6'h13
`define XO_TO_COUNT 10'h210
`define INSN_STEP 32'h0000_0004
`define LINK_RESET 32'h0000_0000
`define COUNT_RESET 32'h0000_0000
`endif

// >>> branch_unit_pkg.sv
// Types shared by the branch condition and target unit.
package branch_unit_pkg;
  typedef enum logic [1:0] {
    FORM_NONE = 2'b00,
    FORM_REL = 2'b01,
    FORM_CTR = 2'b10
  } branch_form_e;

  typedef struct packed {
    logic [31:0] count_register;
    logic [31:0] link_register;
    logic [31:0] next_insn_address;
    logic taken;
    logic valid;
  } branch_state_s;
endpackage

// >>> branch_decode_if.sv
// Decoded branch fields passed from the decoder to the resolver.
interface branch_decode_if;
  import branch_unit_pkg::*;
  branch_form_e form;
  logic [4:0] branch_options_field;
  logic [4:0] condition_index_field;
  logic [13:0] displacement_field;
  logic absolute_address_flag;
  logic link_flag;
  modport decoder (output form, branch_options_field, condition_index_field, displacement_field,
                   absolute_address_flag, link_flag);
  modport resolver (input form, branch_options_field, condition_index_field, displacement_field,
                    absolute_address_flag, link_flag);
endinterface

// >>> branch_decoder.sv
// Splits a branch instruction word into its fields.
`include "branch_unit_defines.svh"
module branch_decoder
  import branch_unit_pkg::*;
(
  input wire logic [31:0] i_insn,
  branch_decode_if.decoder dec
);
  // Bits are numbered from the most significant end, so field bit k is word bit 31-k.
  always_comb begin
    dec.form = FORM_NONE;
    if (i_insn[31:26] == `OPC_COND_REL) begin
      dec.form = FORM_REL;
    end else if (i_insn[31:26] == `OPC_COND_REG && i_insn[10:1] == `XO_TO_COUNT) begin
      dec.form = FORM_CTR;
    end
  end
  assign dec.branch_options_field = i_insn[25:21];
  assign dec.condition_index_field = i_insn[20:16];
  assign dec.displacement_field = i_insn[15:2];
  assign dec.absolute_address_flag = i_insn[1];
  assign dec.link_flag = i_insn[0];
endmodule

// >>> branch_fetch_model.sv
// Fetch-side model that packs branch fields into instruction words.
module branch_fetch_model (
  input wire logic [1:0] i_kind,
  input wire logic [4:0] i_bo,
  input wire logic [4:0] i_bi,
  input wire logic [13:0] i_bd,
  input wire logic i_aa,
  input wire logic i_lk,
  output logic [31:0] o_insn
);
  timeunit 1ns;
  timeprecision 1ps;
  // word layout; the count form always keeps option bit 2 set.
  assign o_insn = (i_kind == 2'h0) ? {6'h10, i_bo, i_bi, i_bd, i_aa, i_lk} :
                  (i_kind == 2'h1) ? {6'h13, i_bo | 5'h04, i_bi, 5'h00, 10'h210, i_lk} :
                  {6'h1f, i_bo, i_bi, i_bd, i_aa, i_lk};
endmodule

// >>> branch_condition_target_unit_tb.sv
// Self-checking bench for the branch condition and target unit.
module branch_condition_target_unit_tb;
  import branch_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, issue = 0, cld = 0, lld = 0, aa, lk, hint, res, tkn;
  logic [31:0] insn, current_insn_address = 0, cr = 0, cval = 0, nxt, cnt = 0, lnk = 0, octr, olnk;
  logic [1:0] kd;
  logic [4:0] bo, bi;
  logic [13:0] bd;
  logic [32:0] p;
  int seed = 32'hfe85, err_total = 0, compares = 0, cyc = 0;
  logic [31:0] r;
  logic [4:0] bos [9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14};
  always #4 clk = ~clk;
  branch_fetch_model branch_fetch_model_i (.i_kind(kd), .i_bo(bo), .i_bi(bi), .i_bd(bd), .i_aa(aa),
    .i_lk(lk), .o_insn(insn));
  branch_condition_target_unit branch_condition_target_unit_i (.i_core_clk(clk), .i_nrst(nrst),
    .i_issue(issue), .i_insn(insn), .i_current_insn_address(current_insn_address), .i_condition_register(cr),
    .i_count_load(cld), .i_count_value(cval), .i_link_load(lld), .i_link_value(current_insn_address),
    .o_resolved(res), .o_taken(tkn), .o_predict_hint(hint), .o_next_insn_address(nxt),
    .o_count_register(octr), .o_link_register(olnk));
  // Expected taken flag and next address; the count form never decrements.
  function automatic logic [32:0] predict(input logic [1:0] k, input logic [4:0] o, input logic [4:0] b,
    input logic [13:0] d, input logic a, input logic [31:0] pc, input logic [31:0] c, input logic [31:0] crv);
    logic [31:0] nc;
    logic t;
    nc = (k == 2'h0 && !o[2]) ? c - 32'h0000_0001 : c;
    t = (o[2] | ((nc == 32'h0000_0000) == o[1])) & (o[4] | (crv[31 - b] == o[3]));
    if (k == 2'h1) return {t, t ? {c[31:2], 2'b00} : pc + 32'h0000_0004};
    return {t, t ? (a ? 32'h0000_0000 : pc) + {{16{d[13]}}, d, 2'b00} : pc + 32'h0000_0004};
  endfunction
  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    chk32({31'h0, e}, {31'h0, g});
  endtask
  task automatic results;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The run needs about 410 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      kd = r[1:0];
      bo = bos[r[7:4] % 9] | {4'h0, r[8]};
      {lk, aa, bd, bi} = r[29:9];
      cval = {30'h0, r[31:30]};
      if (k < 3) begin
        kd = (k == 0) ? 2'h3 : 2'(k - 1);
        bo = (k == 1) ? 5'h12 : 5'h14;
        cval = 32'h0000_0001;
        lk = 1;
      end
      if (kd == 2'h1) bo = bo | 5'h04;
      current_insn_address = $random(seed) & 32'hffff_fffc;
      cr = $random(seed);
      issue = (kd != 2'h3);
      cld = (kd == 2'h3);
      lld = cld;
      p = predict(kd, bo, bi, bd, aa, current_insn_address, cnt, cr);
      #1 chk1(bo[0], hint);
      @(negedge clk);
      if (kd == 2'h3) begin
        cnt = cval;
        lnk = current_insn_address;
      end else if (kd != 2'h2) begin
        chk1(p[32], tkn);
        chk32(p[31:0], nxt);
        if (kd == 2'h0 && !bo[2]) cnt = cnt - 32'h0000_0001;
        if (lk) lnk = current_insn_address + 32'h0000_0004;
      end
      chk1(kd < 2'h2, res);
      chk32(cnt, octr);
      chk32(lnk, olnk);
      if (k == 2) $display("test corner done");
    end
    issue = 0;
    cld = 0;
    lld = 0;
    $display("test random done");
    // Mid-run reset, then a count branch issued at the first edge after release.
    nrst = 0;
    @(negedge clk);
    nrst = 1;
    cnt = 32'h0000_0000;
    lnk = 32'h0000_0000;
    chk1(1'b0, res);
    chk32(cnt, octr);
    chk32(lnk, olnk);
    kd = 2'h0;
    bo = 5'h10;
    lk = 0;
    aa = 0;
    issue = 1;
    p = predict(kd, bo, bi, bd, aa, current_insn_address, cnt, cr);
    @(negedge clk);
    issue = 0;
    chk1(p[32], tkn);
    chk32(p[31:0], nxt);
    chk32(32'hffff_ffff, octr);
    $display("test reset done");
    results();
  end
endmodule
